// ---- common/wdm_regs.svh ----
// register offsets, field positions, reset values and counts for the timer
`ifndef WDM_REGS_SVH
`define WDM_REGS_SVH

// register port widths
`define WDM_ADDR_W 4
`define WDM_DATA_W 8

// register offsets (byte addresses on the register port)
`define WDM_CTRL_OFS 4'h0
`define WDM_CNT_OFS  4'h4
`define WDM_STAT_OFS 4'h8
`define WDM_MASK_OFS 4'hc

// control register field positions
`define WDM_OVF_BIT  7
`define WDM_MODE_BIT 6
`define WDM_EN_BIT   5
`define WDM_SRC_BIT  4
`define WDM_ACT_BIT  3

// interrupt status and mask field positions
`define WDM_ST_IVL_BIT 0
`define WDM_ST_NMI_BIT 1
`define WDM_ST_RST_BIT 2
`define WDM_ST_W       3

// reset values
`define WDM_CTRL_RST 8'h00
`define WDM_MASK_RST 3'h0
`define WDM_CNT_RST  8'h00

// counter terminal value before the wrap
`define WDM_CNT_MAX 8'hff

// prescaler division counts, in core clock cycles per tick
`define WDM_MAIN_DIV 2
`define WDM_SUB_DIV  610

`endif

// ---- common/wdm_pkg.sv ----
// shared types of the watchdog mode control block
package wdm_pkg;
    // one byte of register data
    typedef logic [7:0] wdm_byte_t;
    // timer operating mode
    typedef enum logic {WDM_MODE_INTERVAL, WDM_MODE_WATCHDOG} wdm_mode_e;
    // action taken on a watchdog overflow
    typedef enum logic {WDM_ACT_NMI, WDM_ACT_RESET} wdm_action_e;
endpackage

// ---- verilog/wdm_prescaler.sv ----
// free running divider giving a one-cycle tick enable every DIV cycles
`include "wdm_regs.svh"
module wdm_prescaler #(
    parameter int unsigned DIV = `WDM_MAIN_DIV
) (
    input  wire logic core_clk,
    input  wire logic rst,
    output logic      tick
);
    // width of the divide counter, at least one bit
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    // terminal value of the divide counter
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] div_reg;   // cycles since the last tick

    // count up and pulse on the terminal value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= '0;
            tick    <= 1'b0;
        end else if (div_reg == LAST) begin
            div_reg <= '0;
            tick    <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            tick    <= 1'b0;
        end
    end
endmodule

// ---- verilog/wdm_up_counter.sv ----
// 8-bit up counter, held at zero while disabled, with overflow pulse
`include "wdm_regs.svh"
module wdm_up_counter (
    input  wire logic      core_clk,
    input  wire logic      rst,
    input  wire logic      count_enable,
    input  wire logic      tick,
    output wdm_pkg::wdm_byte_t count,
    output logic           overflow
);
    // counter value, cleared whenever counting is disabled
    always_ff @(posedge core_clk) begin
        if (rst || !count_enable) begin
            count <= `WDM_CNT_RST;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

    // one-cycle pulse in the cycle the counter shows zero after the wrap
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflow <= 1'b0;
        end else begin
            overflow <= count_enable && tick && (count == `WDM_CNT_MAX);
        end
    end
endmodule

// ---- verilog/wdm_mode_control.sv ----
// watchdog and interval timer control: registers, counter, overflow actions
//
// Chosen here: the placing of the registers and the plain strobed port.
`include "wdm_regs.svh"
module wdm_mode_control #(
    parameter int unsigned MAIN_DIV = `WDM_MAIN_DIV,
    parameter int unsigned SUB_DIV  = `WDM_SUB_DIV
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic [`WDM_ADDR_W-1:0] reg_addr,
    input  wire logic [`WDM_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`WDM_DATA_W-1:0] reg_rdata,
    output logic                        nmi_req,
    output logic                        internal_reset_req,
    output logic                        irq
);

    // true when the address selects the given register
    function automatic logic addr_hit(
        input logic [`WDM_ADDR_W-1:0] addr,
        input logic [`WDM_ADDR_W-1:0] ofs
    );
        addr_hit = (addr == ofs);
    endfunction

    // control register bits
    wdm_pkg::wdm_mode_e   timer_mode_select;       // interval or watchdog
    logic                 count_enable;            // counter runs when set
    logic                 prescaler_source_select; // main or subclock tap
    wdm_pkg::wdm_action_e overflow_action_select;  // nmi or reset
    logic                 overflow_flag;           // counter wrapped
    logic                 ovf_armed_reg;           // flag seen by a read

    // interrupt status and mask
    logic [`WDM_ST_W-1:0] irq_stat_reg;  // sticky event bits
    logic [`WDM_ST_W-1:0] irq_mask_reg;  // enables per event
    logic [`WDM_ST_W-1:0] irq_set;       // events this cycle

    // prescaler taps and counter
    logic                 main_tick;     // main-clock prescaler tick
    logic                 sub_tick;      // subclock prescaler tick
    logic                 cnt_tick;      // selected tick
    wdm_pkg::wdm_byte_t   up_counter;    // counter value
    logic                 cnt_ovf;       // wrap pulse

    // decoded bus accesses
    logic                 ctrl_wr;       // write to control
    logic                 ctrl_rd;       // read of control
    logic                 stat_wr;       // write to status
    logic                 mask_wr;       // write to mask

    // overflow events split by mode and action
    logic                 wd_ovf;        // overflow in watchdog mode
    logic                 nmi_evt;       // watchdog overflow, nmi
    logic                 rst_evt;       // watchdog overflow, reset
    logic                 ivl_evt;       // overflow in interval mode
    logic                 flag_clr;      // software or reset clears flag

    // read data mux output
    logic [`WDM_DATA_W-1:0] rd_mux;

    // main-clock prescaler
    wdm_prescaler #(
        .DIV (MAIN_DIV)
    ) u_main_pre (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (main_tick)
    );

    // subclock-rate prescaler, derived from the core clock
    wdm_prescaler #(
        .DIV (SUB_DIV)
    ) u_sub_pre (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (sub_tick)
    );

    // pick the tick that drives the counter
    always_comb begin
        if (prescaler_source_select) begin
            cnt_tick = sub_tick;
        end else begin
            cnt_tick = main_tick;
        end
    end

    // the up counter itself
    wdm_up_counter u_counter (
        .core_clk     (core_clk),
        .rst          (rst),
        .count_enable (count_enable),
        .tick         (cnt_tick),
        .count        (up_counter),
        .overflow     (cnt_ovf)
    );

    // bus access decode
    always_comb begin
        ctrl_wr = reg_wr && addr_hit(reg_addr, `WDM_CTRL_OFS);
        ctrl_rd = reg_rd && addr_hit(reg_addr, `WDM_CTRL_OFS);
        stat_wr = reg_wr && addr_hit(reg_addr, `WDM_STAT_OFS);
        mask_wr = reg_wr && addr_hit(reg_addr, `WDM_MASK_OFS);
    end

    // overflow events by mode and action
    always_comb begin
        // watchdog only when the mode bit is one
        wd_ovf  = cnt_ovf &&
                  (timer_mode_select == wdm_pkg::WDM_MODE_WATCHDOG);
        // action select routes the watchdog overflow
        nmi_evt = wd_ovf &&
                  (overflow_action_select == wdm_pkg::WDM_ACT_NMI);
        rst_evt = wd_ovf &&
                  (overflow_action_select == wdm_pkg::WDM_ACT_RESET);
        // interval mode overflow only raises the interval event
        ivl_evt = cnt_ovf &&
                  (timer_mode_select == wdm_pkg::WDM_MODE_INTERVAL);
    end

    // control bits written by software
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_mode_select       <= wdm_pkg::WDM_MODE_INTERVAL;
            count_enable            <= 1'b0;
            prescaler_source_select <= 1'b0;
            overflow_action_select  <= wdm_pkg::WDM_ACT_NMI;
        end else if (ctrl_wr) begin
            // mode bit
            if (reg_wdata[`WDM_MODE_BIT]) begin
                timer_mode_select <= wdm_pkg::WDM_MODE_WATCHDOG;
            end else begin
                timer_mode_select <= wdm_pkg::WDM_MODE_INTERVAL;
            end
            // enable bit; clearing it zeroes the counter
            count_enable            <= reg_wdata[`WDM_EN_BIT];
            // tick source bit
            prescaler_source_select <= reg_wdata[`WDM_SRC_BIT];
            // overflow action bit
            if (reg_wdata[`WDM_ACT_BIT]) begin
                overflow_action_select <= wdm_pkg::WDM_ACT_RESET;
            end else begin
                overflow_action_select <= wdm_pkg::WDM_ACT_NMI;
            end
        end
    end

    // flag clear: write of 0 after an arming read, or the reset action
    always_comb begin
        flag_clr = (ctrl_wr && !reg_wdata[`WDM_OVF_BIT] && ovf_armed_reg)
                   || rst_evt;
    end

    // overflow flag; a wrap that is not a reset action wins over a software clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (cnt_ovf && !rst_evt) begin
            overflow_flag <= 1'b1;
        end else if (flag_clr) begin
            overflow_flag <= 1'b0;
        end
    end

    // remembers that software read the flag while it was one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovf_armed_reg <= 1'b0;
        end else if (ctrl_rd && overflow_flag) begin
            ovf_armed_reg <= 1'b1;
        end else if (ctrl_wr || rst_evt) begin
            // any control write uses up the arming read, unless a read of the set flag in the same cycle arms it
            ovf_armed_reg <= 1'b0;
        end
    end

    // one-cycle request pulses to the interrupt and reset controllers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            nmi_req            <= 1'b0;
            internal_reset_req <= 1'b0;
        end else begin
            nmi_req            <= nmi_evt;
            internal_reset_req <= rst_evt;
        end
    end

    // events feeding the sticky status bits
    always_comb begin
        irq_set                  = '0;
        irq_set[`WDM_ST_IVL_BIT] = ivl_evt;
        irq_set[`WDM_ST_NMI_BIT] = nmi_evt;
        irq_set[`WDM_ST_RST_BIT] = rst_evt;
    end

    // sticky status; write one clears, a new event wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_stat_reg <= '0;
        end else if (stat_wr) begin
            irq_stat_reg <= (irq_stat_reg &
                             ~reg_wdata[`WDM_ST_W-1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    // interrupt mask register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_mask_reg <= `WDM_MASK_RST;
        end else if (mask_wr) begin
            irq_mask_reg <= reg_wdata[`WDM_ST_W-1:0];
        end
    end

    // level interrupt while any unmasked status bit is set
    always_comb begin
        irq = |(irq_stat_reg & irq_mask_reg);
    end

    // read data selection by address
    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            `WDM_CTRL_OFS: begin
                // control register view
                rd_mux[`WDM_OVF_BIT]  = overflow_flag;
                rd_mux[`WDM_MODE_BIT] =
                    (timer_mode_select == wdm_pkg::WDM_MODE_WATCHDOG);
                rd_mux[`WDM_EN_BIT]   = count_enable;
                rd_mux[`WDM_SRC_BIT]  = prescaler_source_select;
                rd_mux[`WDM_ACT_BIT]  =
                    (overflow_action_select == wdm_pkg::WDM_ACT_RESET);
            end
            `WDM_CNT_OFS: begin
                // live counter value
                rd_mux = up_counter;
            end
            `WDM_STAT_OFS: begin
                // sticky event bits
                rd_mux[`WDM_ST_W-1:0] = irq_stat_reg;
            end
            `WDM_MASK_OFS: begin
                // event enables
                rd_mux[`WDM_ST_W-1:0] = irq_mask_reg;
            end
            default: begin
                // unmapped addresses read zero
                rd_mux = '0;
            end
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// ---- bench/wdm_mode_control_chk.sv ----
// port checker for the watchdog mode control block
`include "wdm_regs.svh"
module wdm_mode_control_chk (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic [`WDM_ADDR_W-1:0] reg_addr,
    input wire logic [`WDM_DATA_W-1:0] reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [`WDM_DATA_W-1:0] reg_rdata,
    input wire logic                   nmi_req,
    input wire logic                   internal_reset_req,
    input wire logic                   irq
);
    logic       mode_sh; // shadow of the mode bit
    logic       act_sh;  // shadow of the action bit
    logic       en_sh;   // shadow of the enable bit
    logic [2:0] mask_sh; // shadow of the mask register

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // follow software writes to control and mask
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_sh <= 1'b0;
            act_sh  <= 1'b0;
            en_sh   <= 1'b0;
            mask_sh <= 3'h0;
        end else if (reg_wr && reg_addr == `WDM_CTRL_OFS) begin
            mode_sh <= reg_wdata[`WDM_MODE_BIT];
            act_sh  <= reg_wdata[`WDM_ACT_BIT];
            en_sh   <= reg_wdata[`WDM_EN_BIT];
        end else if (reg_wr && reg_addr == `WDM_MASK_OFS) begin
            mask_sh <= reg_wdata[2:0];
        end
    end

    // counter read in the second of two stopped cycles
    sequence s_cnt_rd_stopped;
        !en_sh ##1 (!en_sh && reg_rd && reg_addr == `WDM_CNT_OFS);
    endsequence

    // requests are launched from the settings of the cycle before
    a_nmi_cause: assert property (
        nmi_req |-> $past(mode_sh) && !$past(act_sh))
        else $error("nmi request without watchdog nmi setting");
    a_rst_cause: assert property (
        internal_reset_req |-> $past(mode_sh) && $past(act_sh))
        else $error("reset request without watchdog reset setting");
    a_nmi_pulse: assert property (nmi_req |=> !nmi_req)
        else $error("nmi request longer than one cycle");
    a_rst_pulse: assert property (
        internal_reset_req |=> !internal_reset_req)
        else $error("reset request longer than one cycle");
    a_ctrl_readback: assert property (
        $past(reg_rd && reg_addr == `WDM_CTRL_OFS)
        |-> reg_rdata[5] == $past(en_sh) && reg_rdata[6] == $past(mode_sh)
        && reg_rdata[3] == $past(act_sh) && reg_rdata[2:0] == 3'h0)
        else $error("control read back differs from written bits");
    a_stop_zero: assert property (
        s_cnt_rd_stopped |=> reg_rdata == 8'h00)
        else $error("stopped counter not zero");
    a_irq_masked: assert property (irq |-> mask_sh != 3'h0)
        else $error("interrupt with every source masked");
    a_nmi_irq: assert property (nmi_req && mask_sh[1] |-> irq)
        else $error("unmasked nmi event gives no interrupt");
    a_rst_irq: assert property (internal_reset_req && mask_sh[2] |-> irq)
        else $error("unmasked reset event gives no interrupt");
    a_first_idle: assert property (
        $fell(rst) |-> !nmi_req && !irq && !internal_reset_req)
        else $error("outputs active right after reset");
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the watchdog mode control block
`include "wdm_regs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    $display("BAD %s expected %h seen %h", nm, ex, got); err_total++; end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned MAIN_DIV = 2; // short main prescaler
    localparam int unsigned SUB_DIV  = 4; // short subclock prescaler
    logic       core_clk;           // core clock
    logic       rst;                // synchronous reset
    logic [3:0] reg_addr;           // register address
    logic [7:0] reg_wdata;          // write data
    logic       reg_wr;             // write strobe
    logic       reg_rd;             // read strobe
    logic [7:0] reg_rdata;          // read data
    logic       nmi_req;            // nmi request pulse
    logic       internal_reset_req; // reset request pulse
    logic       irq;                // level interrupt
    logic [7:0] rv;                 // last value read
    int         err_total = 0;      // mismatches
    int         compares  = 0;      // comparisons made
    int         cycles    = 0;      // cycles since start
    int         req_seen  = 0;      // request pulses seen

    wdm_mode_control #(.MAIN_DIV(MAIN_DIV), .SUB_DIV(SUB_DIV))
        i_wdm_mode_control (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_req(nmi_req),
        .internal_reset_req(internal_reset_req), .irq(irq));

    // 50 ns clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // hang guard and request counter
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (nmi_req === 1'b1 || internal_reset_req === 1'b1) req_seen++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // counts then verdict
    task automatic finish_test();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // one-cycle read, data taken in the next cycle
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    // wait for one request pulse, bounded
    task automatic wait_req(input logic want_rst);
        int   n;
        logic got;   // the request that should pulse
        logic other; // the request that must stay low
        n = 0;
        while ((want_rst ? internal_reset_req : nmi_req) !== 1'b1
               && n < 700) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        got   = want_rst ? internal_reset_req : nmi_req;
        other = want_rst ? nmi_req : internal_reset_req;
        `CHK("request", 1'b1, got)
        `CHK("other request", 1'b0, other)
        `CHK("irq on request", 1'b1, irq)
    endtask

    // reset values, unmapped and read-only places
    task automatic t_reset();
        logic [3:0] ofs [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
        foreach (ofs[i]) begin
            rd(ofs[i]);
            `CHK("reset value", 8'h00, rv)
        end
        wr(4'h2, 8'hff);
        wr(`WDM_CNT_OFS, 8'h55);
        rd(`WDM_CTRL_OFS);
        `CHK("ctrl untouched", 8'h00, rv)
        rd(`WDM_CNT_OFS);
        `CHK("count read only", 8'h00, rv)
    endtask

    // interval overflow, flag clear, stop
    task automatic t_interval();
        int n;
        wr(`WDM_CTRL_OFS, 8'h20);
        rd(`WDM_CTRL_OFS);
        `CHK("ctrl enable", 8'h20, rv)
        rd(`WDM_CNT_OFS);
        `CHK("counting", 1'b1, rv != 8'h00)
        n = 0;
        do begin
            rd(`WDM_CTRL_OFS);
            n++;
        end while (rv[7] !== 1'b1 && n < 400);
        `CHK("flag on wrap", 8'ha0, rv)
        `CHK("masked irq", 1'b0, irq)
        `CHK("no requests", 0, req_seen)
        rd(`WDM_STAT_OFS);
        `CHK("interval status", 8'h01, rv)
        // a one in the flag bit never clears it, and disarms
        wr(`WDM_CTRL_OFS, 8'ha0);
        // a zero without a fresh arming read leaves the flag
        wr(`WDM_CTRL_OFS, 8'h20);
        rd(`WDM_CTRL_OFS);
        `CHK("flag kept", 8'ha0, rv)
        wr(`WDM_CTRL_OFS, 8'h20);
        rd(`WDM_CTRL_OFS);
        `CHK("flag cleared", 8'h20, rv)
        wr(`WDM_STAT_OFS, 8'h01);
        wr(`WDM_CTRL_OFS, 8'h00);
        rd(`WDM_STAT_OFS);
        `CHK("status cleared", 8'h00, rv)
        rd(`WDM_CNT_OFS);
        `CHK("stopped count", 8'h00, rv)
    endtask

    // watchdog overflow with either action
    task automatic t_watchdog(input logic [7:0] c, input logic [7:0] m,
                              input logic [7:0] ex_ctrl);
        wr(`WDM_MASK_OFS, m);
        wr(`WDM_CTRL_OFS, c);
        wait_req(c[`WDM_ACT_BIT]);
        rd(`WDM_CTRL_OFS);
        `CHK("ctrl after overflow", ex_ctrl, rv)
        rd(`WDM_STAT_OFS);
        `CHK("watchdog status", m, rv)
        wr(`WDM_STAT_OFS, m);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        wr(`WDM_CTRL_OFS, 8'h00);
    endtask

    // counter rate for a prescaler choice
    task automatic rate(input logic [7:0] c, input int lo, input int hi);
        wr(`WDM_CTRL_OFS, c);
        repeat (40) @(posedge core_clk);
        rd(`WDM_CNT_OFS);
        wr(`WDM_CTRL_OFS, 8'h00);
        `CHK("tick rate", 1'b1, rv >= lo && rv <= hi)
    endtask

    // main sequence
    initial begin
        rst       = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_interval();
        t_watchdog(8'h60, 8'h02, 8'he0);
        t_watchdog(8'h68, 8'h04, 8'h68);
        rate(8'h30, 9, 12);
        rate(8'h20, 18, 23);
        finish_test();
    end
endmodule

bind wdm_mode_control wdm_mode_control_chk i_chk (.core_clk(core_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nmi_req(nmi_req), .internal_reset_req(internal_reset_req), .irq(irq));
